//--- inc/uws_defs.svh
`ifndef UWS_DEFS_SVH
`define UWS_DEFS_SVH

// Register byte offsets
`define UWS_ADDR_DATA 12'h000
`define UWS_ADDR_RSR 12'h004
`define UWS_ADDR_FLAG 12'h018
`define UWS_ADDR_ILPR 12'h020
`define UWS_ADDR_IBRD 12'h024
`define UWS_ADDR_FBRD 12'h028
`define UWS_ADDR_LCRH 12'h02c
`define UWS_ADDR_CTL 12'h030
`define UWS_ADDR_IFLS 12'h034
`define UWS_ADDR_STAT 12'h044

// Reset values
`define UWS_CTL_RST 10'h300
`define UWS_IFLS_RST 6'h12

// Control register bit positions
`define UWS_CTL_EN 0
`define UWS_CTL_SIR 1
`define UWS_CTL_SIRLP 2
`define UWS_CTL_TXE 8
`define UWS_CTL_RXE 9

// Receive status bit positions
`define UWS_RSR_FE 0
`define UWS_RSR_PE 1
`define UWS_RSR_BE 2
`define UWS_RSR_OE 3

// FIFO geometry
`define UWS_FIFO_DEPTH 5'h10
`define UWS_ENTRY_W 12

// Oversampling and timing counts
`define UWS_OS_LAST 4'hf
`define UWS_OS_MID 4'h7
`define UWS_FRAC_ONE 23'h000040
`define UWS_SIR_PULSE 4'h3
`define UWS_LP_PULSE 2'h3
`define UWS_IR_HOLD 5'h10
`define UWS_RTO_TICKS 10'h200

`endif

//--- inc/uws_pkg.sv
package uws_pkg;

	typedef struct packed {
		logic sps;
		logic [1:0] wlen;
		logic fifo_enable;
		logic stp2;
		logic eps;
		logic pen;
		logic brk;
	} uws_lcr_t;

	typedef struct packed {
		logic overrun;
		logic brk_err;
		logic par_err;
		logic frm_err;
		logic [7:0] data;
	} uws_rx_entry_t;

	typedef enum logic [2:0] {
		UWS_IDLE,
		UWS_START,
		UWS_DATA,
		UWS_PAR,
		UWS_STOP
	} uws_state_t;

endpackage : uws_pkg

//--- rtl/uws_top.sv
`timescale 1ns/10ps
`include "uws_defs.svh"

module uws_top (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [11:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic serial_in_pin_i,
	output logic [31:0] rdata_o,
	output logic serial_out_pin_o
);

	// Software-visible registers
	logic [9:0] control_reg;
	logic [15:0] int_divisor_reg;
	logic [5:0] frac_divisor_reg;
	logic [7:0] line_control_reg;
	logic [7:0] lowpower_div_reg;
	logic [5:0] fifo_level_select_reg;
	logic [3:0] receive_error_reg;
	// Active copy of divisors and line control
	logic [15:0] div_int_act_reg;
	logic [5:0] div_frac_act_reg;
	uws_pkg::uws_lcr_t lcr;

	logic port_enable;
	logic wr_data, rd_data, wr_lcrh;
	assign port_enable = control_reg[`UWS_CTL_EN];
	assign wr_data = wr_i && (addr_i == `UWS_ADDR_DATA);
	assign rd_data = rd_i && (addr_i == `UWS_ADDR_DATA);
	assign wr_lcrh = wr_i && (addr_i == `UWS_ADDR_LCRH);

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			control_reg <= `UWS_CTL_RST;
			int_divisor_reg <= 16'h0000;
			frac_divisor_reg <= 6'h00;
			line_control_reg <= 8'h00;
			lowpower_div_reg <= 8'h00;
			fifo_level_select_reg <= `UWS_IFLS_RST;
		end else if (wr_i) begin
			unique case (addr_i)
				`UWS_ADDR_CTL: control_reg <= wdata_i[9:0];
				`UWS_ADDR_IBRD: int_divisor_reg <= wdata_i[15:0];
				`UWS_ADDR_FBRD: frac_divisor_reg <= wdata_i[5:0];
				`UWS_ADDR_LCRH: line_control_reg <= wdata_i[7:0];
				`UWS_ADDR_ILPR: lowpower_div_reg <= wdata_i[7:0];
				`UWS_ADDR_IFLS: fifo_level_select_reg <= wdata_i[5:0];
				default: ;
			endcase
		end
	end

	// The 30-bit active set only changes on a line control write
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_int_act_reg <= 16'h0000;
			div_frac_act_reg <= 6'h00;
			lcr <= '0;
		end else if (wr_lcrh) begin
			div_int_act_reg <= int_divisor_reg;
			div_frac_act_reg <= frac_divisor_reg;
			lcr <= uws_pkg::uws_lcr_t'(wdata_i[7:0]);
		end
	end

	// Fractional divider: average period of div64/64 clocks per tick
	logic [22:0] frac_acc_reg, frac_sum;
	logic [21:0] div64;
	logic os_tick_reg;
	assign div64 = {div_int_act_reg, div_frac_act_reg};
	assign frac_sum = frac_acc_reg + `UWS_FRAC_ONE;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			frac_acc_reg <= 23'h000000;
			os_tick_reg <= 1'b0;
		end else if ({1'b0, div64} < `UWS_FRAC_ONE) begin
			frac_acc_reg <= 23'h000000;
			os_tick_reg <= (div64 != 22'h000000);
		end else if (frac_sum >= {1'b0, div64}) begin
			frac_acc_reg <= frac_sum - {1'b0, div64};
			os_tick_reg <= 1'b1;
		end else begin
			frac_acc_reg <= frac_sum;
			os_tick_reg <= 1'b0;
		end
	end

	// Low-power infrared tick divider
	logic [7:0] lp_cnt_reg;
	logic lp_tick_reg;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lp_cnt_reg <= 8'h00;
			lp_tick_reg <= 1'b0;
		end else if (lp_cnt_reg == lowpower_div_reg - 8'h01) begin
			lp_cnt_reg <= 8'h00;
			lp_tick_reg <= 1'b1;
		end else begin
			lp_cnt_reg <= lp_cnt_reg + 8'h01;
			lp_tick_reg <= 1'b0;
		end
	end

	// FIFOs: index 0 transmit, index 1 receive
	logic [1:0] f_push, f_pop;
	logic [`UWS_ENTRY_W-1:0] f_din [2];
	logic [`UWS_ENTRY_W-1:0] f_dout [2];
	logic [4:0] f_cnt [2];
	logic [1:0] f_full, f_empty;
	logic [4:0] f_depth;
	assign f_depth = lcr.fifo_enable ? `UWS_FIFO_DEPTH : 5'h01;

	for (genvar g = 0; g < 2; g++) begin : g_fifo
		logic [`UWS_ENTRY_W-1:0] mem [16];
		logic [3:0] wp_reg, rp_reg;
		logic [4:0] cnt_reg;
		logic do_push, do_pop;
		assign f_full[g] = (cnt_reg >= f_depth);
		assign f_empty[g] = (cnt_reg == 5'h00);
		assign do_push = f_push[g] && !f_full[g];
		assign do_pop = f_pop[g] && !f_empty[g];
		assign f_dout[g] = mem[rp_reg];
		assign f_cnt[g] = cnt_reg;

		always_ff @(posedge sys_clk_i) begin
			if (do_push) begin
				mem[wp_reg] <= f_din[g];
			end
		end

		always_ff @(posedge sys_clk_i or posedge rst_i) begin
			if (rst_i) begin
				wp_reg <= 4'h0;
				rp_reg <= 4'h0;
				cnt_reg <= 5'h00;
			end else begin
				if (do_push) begin
					wp_reg <= wp_reg + 4'h1;
				end
				if (do_pop) begin
					rp_reg <= rp_reg + 4'h1;
				end
				cnt_reg <= cnt_reg + {4'h0, do_push} - {4'h0, do_pop};
			end
		end
	end

	// Trigger level in entries for a 16-deep FIFO
	function automatic logic [4:0] level_of(input logic [2:0] sel);
		unique case (sel)
			3'h0: level_of = 5'h02;
			3'h1: level_of = 5'h04;
			3'h2: level_of = 5'h08;
			3'h3: level_of = 5'h0c;
			default: level_of = 5'h0e;
		endcase
	endfunction : level_of

	logic tx_level_hit, rx_level_hit;
	assign tx_level_hit = f_cnt[0] <= level_of(fifo_level_select_reg[2:0]);
	assign rx_level_hit = f_cnt[1] >= level_of(fifo_level_select_reg[5:3]);

	// Transmitter
	uws_pkg::uws_state_t tx_state_reg;
	logic [3:0] tx_os_reg;
	logic [2:0] tx_idx_reg;
	logic [7:0] tx_shift_reg;
	logic tx_stop2_reg, tx_newbit_reg, tx_bit;
	logic [2:0] data_last;
	logic tx_go;
	assign data_last = {1'b1, lcr.wlen}; // 4..7 means 5..8 bits
	assign tx_go = port_enable && control_reg[`UWS_CTL_TXE] && !f_empty[0];
	assign f_push[0] = wr_data;
	assign f_din[0] = {4'h0, wdata_i[7:0]};
	assign f_pop[0] = os_tick_reg && tx_state_reg == uws_pkg::UWS_IDLE && tx_go;

	function automatic logic par_of(input logic [7:0] d, input uws_pkg::uws_lcr_t c);
		if (c.sps) begin
			par_of = !c.eps;
		end else begin
			par_of = c.eps ? ^d : ~^d;
		end
	endfunction : par_of

	always_comb begin
		unique case (tx_state_reg)
			uws_pkg::UWS_START: tx_bit = 1'b0;
			uws_pkg::UWS_DATA: tx_bit = tx_shift_reg[tx_idx_reg];
			uws_pkg::UWS_PAR: tx_bit = par_of(tx_shift_reg, lcr);
			default: tx_bit = 1'b1;
		endcase
	end

	// A new character starts only while enabled; one in flight always completes
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_state_reg <= uws_pkg::UWS_IDLE;
			tx_os_reg <= 4'h0;
			tx_idx_reg <= 3'h0;
			tx_shift_reg <= 8'h00;
			tx_stop2_reg <= 1'b0;
			tx_newbit_reg <= 1'b0;
		end else begin
			tx_newbit_reg <= 1'b0;
			if (os_tick_reg) begin
				tx_os_reg <= tx_os_reg + 4'h1;
				unique case (tx_state_reg)
					uws_pkg::UWS_IDLE: begin
						tx_os_reg <= 4'h0;
						if (tx_go) begin
							tx_shift_reg <= f_dout[0][7:0] & (8'hff >> (3'h3 - {1'b0, lcr.wlen}));
							tx_state_reg <= uws_pkg::UWS_START;
							tx_newbit_reg <= 1'b1;
						end
					end
					uws_pkg::UWS_START: begin
						if (tx_os_reg == `UWS_OS_LAST) begin
							tx_state_reg <= uws_pkg::UWS_DATA;
							tx_idx_reg <= 3'h0;
							tx_newbit_reg <= 1'b1;
						end
					end
					uws_pkg::UWS_DATA: begin
						if (tx_os_reg == `UWS_OS_LAST) begin
							tx_newbit_reg <= 1'b1;
							tx_idx_reg <= tx_idx_reg + 3'h1;
							if (tx_idx_reg == data_last) begin
								tx_state_reg <= lcr.pen ? uws_pkg::UWS_PAR : uws_pkg::UWS_STOP;
								tx_stop2_reg <= lcr.stp2;
							end
						end
					end
					uws_pkg::UWS_PAR: begin
						if (tx_os_reg == `UWS_OS_LAST) begin
							tx_state_reg <= uws_pkg::UWS_STOP;
							tx_newbit_reg <= 1'b1;
						end
					end
					uws_pkg::UWS_STOP: begin
						if (tx_os_reg == `UWS_OS_LAST) begin
							tx_stop2_reg <= 1'b0;
							tx_newbit_reg <= tx_stop2_reg;
							if (!tx_stop2_reg) begin
								tx_state_reg <= uws_pkg::UWS_IDLE;
							end
						end
					end
					default: tx_state_reg <= uws_pkg::UWS_IDLE;
				endcase
			end
		end
	end

	// Line encoding: plain, normal infrared, low-power infrared
	logic [1:0] lp_left_reg;
	logic line_bit;
	assign line_bit = tx_bit && !lcr.brk;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lp_left_reg <= 2'h0;
		end else if (tx_newbit_reg && !line_bit) begin
			lp_left_reg <= `UWS_LP_PULSE;
		end else if (lp_tick_reg && lp_left_reg != 2'h0) begin
			lp_left_reg <= lp_left_reg - 2'h1;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			serial_out_pin_o <= 1'b1;
		end else if (!control_reg[`UWS_CTL_SIR]) begin
			serial_out_pin_o <= line_bit;
		end else if (control_reg[`UWS_CTL_SIRLP]) begin
			serial_out_pin_o <= (lp_left_reg != 2'h0);
		end else begin
			serial_out_pin_o <= !line_bit && (tx_os_reg < `UWS_SIR_PULSE);
		end
	end

	// Receiver input: two-stage synchroniser, then optional infrared decode
	logic rx_s1_reg, rx_s2_reg, rx_in;
	logic [4:0] ir_hold_reg;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
		end else begin
			rx_s1_reg <= serial_in_pin_i;
			rx_s2_reg <= rx_s1_reg;
		end
	end

	// An infrared low pulse marks a zero bit for one bit period
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ir_hold_reg <= 5'h00;
		end else if (!rx_s2_reg) begin
			ir_hold_reg <= `UWS_IR_HOLD;
		end else if (os_tick_reg && ir_hold_reg != 5'h00) begin
			ir_hold_reg <= ir_hold_reg - 5'h01;
		end
	end

	assign rx_in = control_reg[`UWS_CTL_SIR] ? (rx_s2_reg && ir_hold_reg == 5'h00) : rx_s2_reg;

	uws_pkg::uws_state_t rx_state_reg;
	logic [3:0] rx_os_reg;
	logic [2:0] rx_idx_reg;
	logic [7:0] rx_shift_reg;
	logic rx_seen_high_reg, rx_any1_reg, rx_perr_reg, rx_push, ovr_pend_reg;
	uws_pkg::uws_rx_entry_t rx_entry;
	assign rx_push = os_tick_reg && rx_state_reg == uws_pkg::UWS_STOP && rx_os_reg == `UWS_OS_LAST;
	assign rx_entry.data = rx_shift_reg;
	assign rx_entry.frm_err = !rx_in;
	assign rx_entry.par_err = rx_perr_reg;
	assign rx_entry.brk_err = !rx_in && !rx_any1_reg;
	assign rx_entry.overrun = ovr_pend_reg;
	assign f_push[1] = rx_push;
	assign f_din[1] = rx_entry;
	assign f_pop[1] = rd_data;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_state_reg <= uws_pkg::UWS_IDLE;
			rx_os_reg <= 4'h0;
			rx_idx_reg <= 3'h0;
			rx_shift_reg <= 8'h00;
			rx_seen_high_reg <= 1'b0;
			rx_any1_reg <= 1'b0;
			rx_perr_reg <= 1'b0;
		end else if (os_tick_reg) begin
			rx_os_reg <= rx_os_reg + 4'h1;
			unique case (rx_state_reg)
				uws_pkg::UWS_IDLE: begin
					rx_os_reg <= 4'h0;
					rx_seen_high_reg <= rx_in;
					if (rx_seen_high_reg && !rx_in && port_enable && control_reg[`UWS_CTL_RXE]) begin
						rx_state_reg <= uws_pkg::UWS_START;
						rx_shift_reg <= 8'h00;
						rx_any1_reg <= 1'b0;
						rx_perr_reg <= 1'b0;
					end
				end
				uws_pkg::UWS_START: begin
					if (rx_os_reg == `UWS_OS_MID) begin
						rx_os_reg <= 4'h0;
						rx_idx_reg <= 3'h0;
						rx_state_reg <= rx_in ? uws_pkg::UWS_IDLE : uws_pkg::UWS_DATA;
					end
				end
				uws_pkg::UWS_DATA: begin
					if (rx_os_reg == `UWS_OS_LAST) begin
						rx_shift_reg[rx_idx_reg] <= rx_in;
						rx_any1_reg <= rx_any1_reg || rx_in;
						rx_idx_reg <= rx_idx_reg + 3'h1;
						if (rx_idx_reg == data_last) begin
							rx_state_reg <= lcr.pen ? uws_pkg::UWS_PAR : uws_pkg::UWS_STOP;
						end
					end
				end
				uws_pkg::UWS_PAR: begin
					if (rx_os_reg == `UWS_OS_LAST) begin
						rx_perr_reg <= rx_in != par_of(rx_shift_reg, lcr);
						rx_any1_reg <= rx_any1_reg || rx_in;
						rx_state_reg <= uws_pkg::UWS_STOP;
					end
				end
				uws_pkg::UWS_STOP: begin
					if (rx_os_reg == `UWS_OS_LAST) begin
						rx_seen_high_reg <= rx_in;
						rx_state_reg <= uws_pkg::UWS_IDLE;
					end
				end
				default: rx_state_reg <= uws_pkg::UWS_IDLE;
			endcase
		end
	end

	// Error status: hardware set wins over a software clear in the same cycle
	logic [3:0] err_set;
	logic rsr_clear;
	assign rsr_clear = wr_i && (addr_i == `UWS_ADDR_RSR);
	assign err_set = rx_push ? {f_full[1], rx_entry.brk_err, rx_entry.par_err,
		rx_entry.frm_err} : 4'h0;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			receive_error_reg <= 4'h0;
		end else begin
			receive_error_reg <= (rsr_clear ? 4'h0 : receive_error_reg) | err_set;
		end
	end

	// Overrun marks the next stored character as well
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ovr_pend_reg <= 1'b0;
		end else if (rx_push) begin
			ovr_pend_reg <= f_full[1];
		end
	end

	// Receive timeout, counted in oversample ticks while the receiver idles
	logic [9:0] rto_cnt_reg;
	logic rx_timeout_reg;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rto_cnt_reg <= 10'h000;
			rx_timeout_reg <= 1'b0;
		end else begin
			if (f_empty[1] || rx_push || f_pop[1] || rx_state_reg != uws_pkg::UWS_IDLE) begin
				rto_cnt_reg <= 10'h000;
			end else if (os_tick_reg && rto_cnt_reg != `UWS_RTO_TICKS) begin
				rto_cnt_reg <= rto_cnt_reg + 10'h001;
			end
			if (f_empty[1]) begin
				rx_timeout_reg <= 1'b0;
			end else if (rto_cnt_reg == `UWS_RTO_TICKS) begin
				rx_timeout_reg <= 1'b1;
			end
		end
	end

	// Register read port, data valid the cycle after the strobe
	logic tx_busy;
	logic [31:0] rd_mux;
	assign tx_busy = !f_empty[0] || tx_state_reg != uws_pkg::UWS_IDLE;

	always_comb begin
		rd_mux = 32'h00000000;
		unique case (addr_i)
			`UWS_ADDR_DATA: rd_mux = {20'h00000, f_dout[1]};
			`UWS_ADDR_RSR: rd_mux = {28'h0000000, receive_error_reg};
			`UWS_ADDR_FLAG: rd_mux = {24'h000000, f_empty[0], f_full[1], f_full[0],
				f_empty[1], tx_busy, 3'h0};
			`UWS_ADDR_ILPR: rd_mux = {24'h000000, lowpower_div_reg};
			`UWS_ADDR_IBRD: rd_mux = {16'h0000, int_divisor_reg};
			`UWS_ADDR_FBRD: rd_mux = {26'h0000000, frac_divisor_reg};
			`UWS_ADDR_LCRH: rd_mux = {24'h000000, line_control_reg};
			`UWS_ADDR_CTL: rd_mux = {22'h000000, control_reg};
			`UWS_ADDR_IFLS: rd_mux = {26'h0000000, fifo_level_select_reg};
			`UWS_ADDR_STAT: rd_mux = {29'h00000000, rx_level_hit, tx_level_hit,
				rx_timeout_reg};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 32'h00000000;
		end else if (rd_i) begin
			rdata_o <= rd_mux;
		end else begin
			rdata_o <= 32'h00000000;
		end
	end

endmodule : uws_top

//--- tb/uws_sva.sv
`timescale 1ns/10ps
`include "uws_defs.svh"
module uws_chk (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [11:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic serial_in_pin_i,
	input wire logic [31:0] rdata_o,
	input wire logic serial_out_pin_o
);
	logic ctl_written_reg;
	logic sir_reg;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// Tracks whether control was written since reset and the infrared mode last written
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctl_written_reg <= 1'b0;
			sir_reg <= 1'b0;
		end else if (wr_i && addr_i == `UWS_ADDR_CTL) begin
			ctl_written_reg <= 1'b1;
			sir_reg <= wdata_i[`UWS_CTL_SIR];
		end
	end
	a_rdata_quiet: assert property (
		!rd_i |=> rdata_o == 32'h0) else $error("read data not zero outside a read");
	a_data_width: assert property (
		rd_i && addr_i == `UWS_ADDR_DATA |=> rdata_o[31:12] == 20'h0)
		else $error("data read wider than twelve bits");
	a_ctl_reset: assert property (
		rd_i && addr_i == `UWS_ADDR_CTL && !ctl_written_reg |=> rdata_o == 32'h300)
		else $error("control not at its reset value");
	a_flag_sane: assert property (
		rd_i && addr_i == `UWS_ADDR_FLAG |=> rdata_o[31:8] == 24'h0
		&& !(rdata_o[7] && rdata_o[5]) && !(rdata_o[4] && rdata_o[6]))
		else $error("flag register inconsistent");
	a_idle_busy: assert property (
		rd_i && addr_i == `UWS_ADDR_FLAG |=> rdata_o[3] || rdata_o[7])
		else $error("not busy while transmit queue holds data");
	a_busy_write: assert property (
		wr_i && addr_i == `UWS_ADDR_DATA ##2 rd_i && addr_i == `UWS_ADDR_FLAG |=> rdata_o[3])
		else $error("busy not set after a data write");
	a_bit_length: assert property (
		!sir_reg && $fell(serial_out_pin_o) |=> (!serial_out_pin_o)[*8]
		##1 (!serial_out_pin_o)[*7]) else $error("low bit shorter than sixteen clocks");
	a_reset_idle: assert property (
		$fell(rst_i) |-> serial_out_pin_o) else $error("serial output not idle after reset");
endmodule : uws_chk

bind uws_top uws_chk uws_chk_i (
	.sys_clk_i(sys_clk_i),
	.rst_i(rst_i),
	.addr_i(addr_i),
	.wdata_i(wdata_i),
	.wr_i(wr_i),
	.rd_i(rd_i),
	.serial_in_pin_i(serial_in_pin_i),
	.rdata_o(rdata_o),
	.serial_out_pin_o(serial_out_pin_o)
);

//--- tb/uws_remote.sv
`timescale 1ns/10ps
module uws_remote #(
	parameter int BIT = 32
) (
	input wire logic clk_i,
	input wire logic line_i,
	input wire logic [9:0] raw_i,
	input wire logic [3:0] n_i,
	input wire logic [7:0] lo_i,
	input wire logic go_i,
	output logic line_o,
	output logic [9:0] got_o,
	output int cnt_o
);
	// Captures n_i bits after each start, sampled mid-bit
	initial begin
		got_o = 10'h3ff;
		cnt_o = 0;
		forever begin
			@(negedge line_i);
			repeat (BIT / 2) @(posedge clk_i);
			for (int i = 0; i < n_i; i++) begin
				repeat (BIT) @(posedge clk_i);
				got_o[i] = line_i;
			end
			cnt_o++;
		end
	end
	// Sends a start of lo_i clocks, then n_i bits least significant first, then idles high
	initial begin
		line_o = 1'b1;
		forever begin
			@(posedge go_i);
			line_o <= 1'b0;
			repeat (lo_i) @(posedge clk_i);
			for (int i = 0; i < n_i; i++) begin
				line_o <= raw_i[i];
				repeat (BIT) @(posedge clk_i);
			end
			line_o <= 1'b1;
		end
	end
endmodule : uws_remote

//--- tb/tb.sv
`timescale 1ns/10ps
`include "uws_defs.svh"
`define CHK(g, e) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("BAD t=%0t got=%h exp=%h", $time, g, e); \
	end \
end
module tb;
	localparam int BIT = 32;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] addr = 12'h0;
	logic [31:0] wdata = 32'h0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [31:0] rdata;
	logic s_out;
	logic s_in;
	logic [9:0] raw = 10'h3ff;
	logic [3:0] nb = 4'ha;
	logic [7:0] lo = 8'h20;
	logic go = 1'b0;
	logic [9:0] got_raw;
	int got_cnt;
	int miscompares = 0;
	int checks_done = 0;
	logic [31:0] d;
	int c0;
	int hc;
	// Line control, byte sent, frame on the wire, byte read back
	logic [33:0] rows [5] = '{{8'h60, 8'ha5, 10'h3a5, 8'ha5}, {8'h0e, 8'h13, 10'h3f3, 8'h13},
		{8'h2a, 8'h2c, 10'h3ac, 8'h2c}, {8'hc2, 8'h55, 10'h3d5, 8'h55},
		{8'he6, 8'hff, 10'h2ff, 8'hff}};
	logic [43:0] rst_rows [7] = '{{12'h018, 32'h90}, {12'h030, 32'h300}, {12'h034, 32'h12},
		{12'h004, 32'h0}, {12'h02c, 32'h0}, {12'h044, 32'h2}, {12'h100, 32'h0}};
	// Control mode bits, low-power divisor, least and most high clocks per frame of zeros
	logic [31:0] sir_rows [2] = '{32'h03003636, 32'h0704516c};

	uws_top uws_top_i (
		.sys_clk_i(sys_clk),
		.rst_i(rst),
		.addr_i(addr),
		.wdata_i(wdata),
		.wr_i(wr_s),
		.rd_i(rd_s),
		.serial_in_pin_i(s_in),
		.rdata_o(rdata),
		.serial_out_pin_o(s_out)
	);
	uws_remote #(.BIT(BIT)) uws_remote_i (
		.clk_i(sys_clk),
		.line_i(s_out),
		.raw_i(raw),
		.n_i(nb),
		.lo_i(lo),
		.go_i(go),
		.line_o(s_in),
		.got_o(got_raw),
		.cnt_o(got_cnt)
	);

	always #10 sys_clk = ~sys_clk;

	task automatic cyc(input logic w, input logic r, input logic [11:0] a, input logic [31:0] v);
		wr_s <= w;
		rd_s <= r;
		addr <= a;
		wdata <= v;
		@(posedge sys_clk);
	endtask : cyc

	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		cyc(1'b1, 1'b0, a, v);
		cyc(1'b0, 1'b0, a, v);
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] v);
		cyc(1'b0, 1'b1, a, 32'h0);
		rd_s <= 1'b0;
		// Read data is taken mid-cycle, where it has settled
		@(negedge sys_clk);
		v = rdata;
		@(posedge sys_clk);
	endtask : rd

	task automatic snd(input logic [9:0] r, input logic [3:0] n, input logic [7:0] l);
		raw <= r;
		nb <= n;
		lo <= l;
		@(posedge sys_clk);
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		repeat (12 * BIT) @(posedge sys_clk);
	endtask : snd

	task automatic wait_cnt(input int t);
		for (int k = 0; k < 8000 && got_cnt < t; k++) @(posedge sys_clk);
		`CHK(got_cnt >= t, 1'b1)
	endtask : wait_cnt

	task automatic end_sim;
		if (miscompares == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim

	initial begin
		repeat (60000) @(posedge sys_clk);
		miscompares++;
		end_sim();
	end

	initial begin
		logic [7:0] lc;
		logic [7:0] dv;
		logic [7:0] rx;
		logic [9:0] rw;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		// Divisor 2.0 gives 32 clocks per bit
		wr(`UWS_ADDR_IBRD, 32'h2);
		for (int i = 0; i < 5; i++) begin
			{lc, dv, rw, rx} = rows[i];
			wr(`UWS_ADDR_CTL, 32'h300);
			wr(`UWS_ADDR_LCRH, {24'h0, lc});
			wr(`UWS_ADDR_CTL, 32'h301);
			c0 = got_cnt;
			wr(`UWS_ADDR_DATA, {24'h0, dv});
			rd(`UWS_ADDR_FLAG, d);
			`CHK(d[3], 1'b1)
			wait_cnt(c0 + 1);
			`CHK(got_raw, rw)
			snd(rw, 4'ha, 8'h20);
			rd(`UWS_ADDR_DATA, d);
			`CHK(d, {24'h0, rx})
		end
		// Second reset in mid-run, then reset values
		rst <= 1'b1;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		foreach (rst_rows[i]) begin
			rd(rst_rows[i][43:32], d);
			`CHK(d, rst_rows[i][31:0])
		end
		// One-deep queue while the port is off
		wr(`UWS_ADDR_IBRD, 32'h2);
		wr(`UWS_ADDR_LCRH, 32'h60);
		nb <= 4'h9;
		wr(`UWS_ADDR_DATA, 32'h11);
		wr(`UWS_ADDR_DATA, 32'h22);
		rd(`UWS_ADDR_FLAG, d);
		`CHK(d[7:0], 8'h38)
		c0 = got_cnt;
		wr(`UWS_ADDR_CTL, 32'h301);
		repeat (800) @(posedge sys_clk);
		`CHK(got_cnt, c0 + 1)
		`CHK(got_raw[8:0], 9'h111)
		// Sixteen-deep queue; divisor change not yet loaded
		wr(`UWS_ADDR_CTL, 32'h300);
		wr(`UWS_ADDR_LCRH, 32'h70);
		wr(`UWS_ADDR_IBRD, 32'h4);
		for (int i = 1; i < 18; i++) wr(`UWS_ADDR_DATA, 32'(i));
		rd(`UWS_ADDR_FLAG, d);
		`CHK(d[7:0], 8'h38)
		c0 = got_cnt;
		wr(`UWS_ADDR_CTL, 32'h301);
		repeat (100) @(posedge sys_clk);
		wr(`UWS_ADDR_CTL, 32'h300);
		repeat (600) @(posedge sys_clk);
		`CHK(got_cnt, c0 + 1)
		`CHK(got_raw[8:0], 9'h101)
		rd(`UWS_ADDR_FLAG, d);
		`CHK(d[3], 1'b1)
		wr(`UWS_ADDR_CTL, 32'h301);
		wait_cnt(c0 + 16);
		repeat (2 * BIT) @(posedge sys_clk);
		rd(`UWS_ADDR_FLAG, d);
		`CHK(d[7:0], 8'h90)
		`CHK(got_cnt, c0 + 16)
		`CHK(got_raw[8:0], 9'h110)
		// Receive errors
		wr(`UWS_ADDR_CTL, 32'h300);
		wr(`UWS_ADDR_IBRD, 32'h2);
		wr(`UWS_ADDR_LCRH, 32'h60);
		wr(`UWS_ADDR_CTL, 32'h301);
		snd(10'h25a, 4'ha, 8'h20);
		rd(`UWS_ADDR_DATA, d);
		`CHK(d, 32'h15a)
		rd(`UWS_ADDR_RSR, d);
		`CHK(d, 32'h1)
		wr(`UWS_ADDR_RSR, 32'h0);
		rd(`UWS_ADDR_RSR, d);
		`CHK(d, 32'h0)
		// Line held low past a whole frame
		snd(10'h000, 4'ha, 8'h20);
		rd(`UWS_ADDR_DATA, d);
		`CHK(d, 32'h500)
		rd(`UWS_ADDR_RSR, d);
		`CHK(d, 32'h5)
		wr(`UWS_ADDR_RSR, 32'h0);
		snd(10'h3ff, 4'h0, 8'h06);
		rd(`UWS_ADDR_FLAG, d);
		`CHK(d[4], 1'b1)
		snd(10'h3a5, 4'ha, 8'h20);
		rd(`UWS_ADDR_FLAG, d);
		`CHK(d[6], 1'b1)
		snd(10'h3c3, 4'ha, 8'h20);
		rd(`UWS_ADDR_RSR, d);
		`CHK(d, 32'h8)
		// Timeout needs 32 idle bit times with data waiting
		repeat (800) @(posedge sys_clk);
		rd(`UWS_ADDR_STAT, d);
		`CHK(d[2:0], 3'h2)
		repeat (300) @(posedge sys_clk);
		rd(`UWS_ADDR_STAT, d);
		`CHK(d[2:0], 3'h3)
		rd(`UWS_ADDR_DATA, d);
		`CHK(d, 32'h0a5)
		rd(`UWS_ADDR_STAT, d);
		`CHK(d[0], 1'b0)
		// Infrared transmit only, nothing received after it
		for (int i = 0; i < 2; i++) begin
			wr(`UWS_ADDR_CTL, 32'h300);
			wr(`UWS_ADDR_ILPR, {24'h0, sir_rows[i][23:16]});
			wr(`UWS_ADDR_CTL, 32'h300 | {24'h0, sir_rows[i][31:24]});
			wr(`UWS_ADDR_DATA, 32'h0);
			hc = 0;
			repeat (420) begin
				@(posedge sys_clk);
				hc += int'(s_out);
			end
			`CHK(hc >= sir_rows[i][15:8] && hc <= sir_rows[i][7:0], 1'b1)
		end
		end_sim();
	end
endmodule : tb
